// ===== parity_pkg.sv
// Constants and carrier types for the byte parity generator and checker.
// Assumes a 16-bit processor data path and a DRAM path of two 9-bit bytes.
package parity_pkg;

    localparam int BYTE_W  = 8;
    localparam int WORD_W  = 16;
    localparam int CODE_W  = 18;
    localparam int LO_BYTE = 0;
    localparam int HI_BYTE = 1;

    // Interrupt number put on the data bus the cycle after acknowledge; arbitrary.
    localparam logic [7:0] IRQ_VECTOR_DEF = 8'h42;

    // Parity sense: 1'b0 gives even parity across the nine stored bits.
    localparam logic PARITY_SENSE = 1'b0;

    localparam logic ERR_RESET = 1'b0;

    // One memory access on the processor side.
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [1:0]        byte_en;
        logic [WORD_W-1:0] wdata;
    } mem_req_s;

    // One word as stored in the array: parity bits and data.
    typedef struct packed {
        logic [1:0]        par;
        logic [WORD_W-1:0] data;
    } mem_word_s;

endpackage : parity_pkg

// ===== byte_parity_error_detector.sv
// Byte parity generator and checker between a processor bus and a DRAM path.
// Assumes the memory controller times the array; reads return data the
// cycle after the read strobe.
`timescale 1ns/1ps

module byte_parity_error_detector
    import parity_pkg::*;
#(
    parameter logic [7:0] IRQ_VECTOR = IRQ_VECTOR_DEF
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire mem_req_s          cpu_req,
    input  wire logic              interrupt_acknowledge,
    input  wire logic              rdata_valid,
    input  wire mem_word_s         mem_rdata,
    output mem_word_s              mem_wdata,
    output logic [1:0]             mem_byte_wr,
    output logic [WORD_W-1:0]      cpu_rdata,
    output logic [BYTE_W-1:0]      vector_out,
    output logic                   vector_oe,
    output logic                   parity_irq,
    output logic [1:0]             err_bytes
);

    function automatic logic byte_parity(input logic [WORD_W-1:0] w,
                                         input int                idx);
        byte_parity = (^w[idx*BYTE_W +: BYTE_W]) ^ PARITY_SENSE;
    endfunction : byte_parity

    // Generated parity for the write path and regenerated for the read path.
    wire logic [1:0] gen_par;
    wire logic [1:0] chk_par;
    wire logic [1:0] mismatch;
    wire logic       any_err;

    assign gen_par[LO_BYTE] = byte_parity(cpu_req.wdata, LO_BYTE);
    assign gen_par[HI_BYTE] = byte_parity(cpu_req.wdata, HI_BYTE);
    assign chk_par[LO_BYTE] = byte_parity(mem_rdata.data, LO_BYTE);
    assign chk_par[HI_BYTE] = byte_parity(mem_rdata.data, HI_BYTE);
    // Stored bit enters the compare directly, so a flipped parity bit shows
    // the same as a flipped data bit; two flips in one byte cancel.
    assign mismatch = rdata_valid ? (chk_par ^ mem_rdata.par)
                                  : 2'b00;
    assign any_err  = |mismatch;

    mem_word_s         wdata_reg;
    logic [1:0]        byte_wr_reg;
    logic              err_reg;
    logic [1:0]        err_bytes_reg;
    logic [WORD_W-1:0] rdata_reg;
    logic              oe_reg;
    logic [BYTE_W-1:0] vector_reg;

    // Next values, decoded here so the clocked blocks stay plain.
    wire logic [1:0]        byte_wr_next;
    wire logic [BYTE_W-1:0] vector_next;
    wire logic              err_set;
    wire logic              err_clear;

    assign byte_wr_next = cpu_req.wr ? cpu_req.byte_en : '0;
    assign vector_next  = interrupt_acknowledge ? IRQ_VECTOR : '0;
    // A set flag ignores further mismatches, but a mismatch arriving with
    // the acknowledge still sets it, so that mismatch is not lost.
    assign err_set   = any_err
                       && (!err_reg || interrupt_acknowledge);
    assign err_clear = interrupt_acknowledge;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wdata_reg   <= '0;
            byte_wr_reg <= 2'b00;
        end else begin
            wdata_reg.data <= cpu_req.wdata;
            wdata_reg.par  <= gen_par;
            byte_wr_reg    <= byte_wr_next;
        end
    end

    // Read data passes through unchanged; nothing is corrected.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg <= '0;
        end else if (rdata_valid) begin
            rdata_reg <= mem_rdata.data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            err_reg       <= ERR_RESET;
            err_bytes_reg <= '0;
        end else if (err_set) begin
            err_reg       <= 1'b1;
            err_bytes_reg <= mismatch;
        end else if (err_clear) begin
            err_reg       <= ERR_RESET;
            err_bytes_reg <= '0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oe_reg     <= 1'b0;
            vector_reg <= '0;
        end else begin
            oe_reg     <= interrupt_acknowledge;
            vector_reg <= vector_next;
        end
    end

    assign mem_wdata   = wdata_reg;
    assign mem_byte_wr = byte_wr_reg;
    assign cpu_rdata   = rdata_reg;
    assign parity_irq  = err_reg;
    assign err_bytes   = err_bytes_reg;
    assign vector_oe   = oe_reg;
    assign vector_out  = vector_reg;

    a_err_sets: assert property (@(posedge clk) disable iff (sys_rst)
        (!err_reg && any_err && !interrupt_acknowledge) |=> parity_irq)
        else $error("Mismatch did not raise interrupt.");

    a_err_holds: assert property (@(posedge clk) disable iff (sys_rst)
        (parity_irq && !interrupt_acknowledge) |=> parity_irq)
        else $error("Error flag dropped without acknowledge.");

    a_ack_clears: assert property (@(posedge clk) disable iff (sys_rst)
        (interrupt_acknowledge && !any_err) |=> !parity_irq)
        else $error("Acknowledge did not clear error flag.");

    a_vec_drive: assert property (@(posedge clk) disable iff (sys_rst)
        vector_oe == $past(interrupt_acknowledge))
        else $error("Vector driver enable wrong.");

    a_no_spur: assert property (@(posedge clk) disable iff (sys_rst)
        (!parity_irq && !any_err) |=> !parity_irq)
        else $error("Error flag set without mismatch.");

    a_byte_wr: assert property (@(posedge clk) disable iff (sys_rst)
        (cpu_req.wr && cpu_req.byte_en == 2'b01) |=>
        (mem_byte_wr == 2'b01))
        else $error("Byte write touched other byte.");

    a_par_gen: assert property (@(posedge clk) disable iff (sys_rst)
        cpu_req.wr |=> (mem_wdata.par[HI_BYTE] ^ ^mem_wdata.data[15:8])
        == PARITY_SENSE)
        else $error("Generated high parity wrong.");

    a_par_flip: assert property (@(posedge clk) disable iff (sys_rst)
        (rdata_valid && (^mem_rdata.data[7:0] ^ PARITY_SENSE)
        != mem_rdata.par[LO_BYTE]) |-> any_err)
        else $error("Low byte error not flagged.");

    a_no_fix: assert property (@(posedge clk) disable iff (sys_rst)
        rdata_valid |=> cpu_rdata == $past(mem_rdata.data))
        else $error("Read data altered.");

    a_ack_loses: assert property (@(posedge clk) disable iff (sys_rst)
        (interrupt_acknowledge && any_err) |=> parity_irq)
        else $error("Mismatch lost in acknowledge cycle.");

    a_err_bytes: assert property (@(posedge clk) disable iff (sys_rst)
        (!parity_irq && any_err) |=> err_bytes == $past(mismatch))
        else $error("Error byte record wrong.");

    a_bytes_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (parity_irq && !interrupt_acknowledge) |=> $stable(err_bytes))
        else $error("Error byte record changed while set.");

    a_bytes_clear: assert property (@(posedge clk) disable iff (sys_rst)
        (interrupt_acknowledge && !any_err) |=> err_bytes == '0)
        else $error("Acknowledge did not clear byte record.");

    a_wr_strobe: assert property (@(posedge clk) disable iff (sys_rst)
        cpu_req.wr |=> mem_byte_wr == $past(cpu_req.byte_en))
        else $error("Write strobes differ from byte enables.");

    a_wr_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !cpu_req.wr |=> mem_byte_wr == '0)
        else $error("Write strobe without write request.");

    a_wr_data: assert property (@(posedge clk) disable iff (sys_rst)
        cpu_req.wr |=> mem_wdata.data == $past(cpu_req.wdata))
        else $error("Stored data differs from written data.");

    a_par_gen_lo: assert property (@(posedge clk) disable iff (sys_rst)
        cpu_req.wr |=> (mem_wdata.par[LO_BYTE] ^ ^mem_wdata.data[7:0])
        == PARITY_SENSE)
        else $error("Generated low parity wrong.");

    a_par_flip_hi: assert property (@(posedge clk) disable iff (sys_rst)
        (rdata_valid && (^mem_rdata.data[15:8] ^ PARITY_SENSE)
        != mem_rdata.par[HI_BYTE]) |-> mismatch[HI_BYTE])
        else $error("High byte error not flagged.");

    a_no_err_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !rdata_valid |-> !any_err)
        else $error("Mismatch reported outside a read.");

    a_rdata_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !rdata_valid |=> $stable(cpu_rdata))
        else $error("Read data changed without a read.");

    a_vec_on: assert property (@(posedge clk) disable iff (sys_rst)
        vector_oe |-> vector_out == IRQ_VECTOR)
        else $error("Wrong interrupt number driven.");

    a_vec_off: assert property (@(posedge clk) disable iff (sys_rst)
        !vector_oe |-> vector_out == '0)
        else $error("Interrupt number shown while not driven.");

endmodule : byte_parity_error_detector

// ===== dram_word_model.sv
// One-word memory model standing on the DRAM side of the parity detector.
// Assumes reads answer the cycle after the read strobe, as the design expects.
`timescale 1ns/1ps
module dram_word_model
    import parity_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rd,
    input  wire logic [17:0] flip,
    input  wire mem_word_s   mem_wdata,
    input  wire logic [1:0]  mem_byte_wr,
    output logic             rdata_valid,
    output mem_word_s        mem_rdata
);
    mem_word_s cell_reg;
    // The cell starts zeroed, as software clears memory after power-up.
    initial begin
        cell_reg = '0;
        rdata_valid = 1'b0;
        mem_rdata = '0;
    end
    always @(posedge clk) begin
        if (mem_byte_wr[1]) begin
            cell_reg.par[1] <= mem_wdata.par[1];
            cell_reg.data[15:8] <= mem_wdata.data[15:8];
        end
        if (mem_byte_wr[0]) begin
            cell_reg.par[0] <= mem_wdata.par[0];
            cell_reg.data[7:0] <= mem_wdata.data[7:0];
        end
        rdata_valid <= rd;
        // Outside a read the bus shows a changing pattern, not old data.
        mem_rdata <= rd ? mem_word_s'(cell_reg ^ flip) : ~mem_rdata;
    end
endmodule : dram_word_model

// ===== byte_parity_error_detector_tb_top.sv
// Self-checking testbench for the byte parity detector.
// Assumes the parity package, the design and the memory model compiled first.
`timescale 1ns/1ps
module byte_parity_error_detector_tb_top import parity_pkg::*;;
    logic clk, sys_rst, ack, rvalid, voe, irq;
    mem_req_s req;
    mem_word_s wd, rdat;
    logic [17:0] flip;
    logic [15:0] shadow, cpu_rdata;
    logic [1:0] bwr, errb;
    logic [7:0] vec;
    int error_cnt = 0;
    int check_count = 0;
    byte_parity_error_detector uut (.clk(clk), .sys_rst(sys_rst),
        .cpu_req(req), .interrupt_acknowledge(ack), .rdata_valid(rvalid),
        .mem_rdata(rdat), .mem_wdata(wd), .mem_byte_wr(bwr),
        .cpu_rdata(cpu_rdata), .vector_out(vec), .vector_oe(voe),
        .parity_irq(irq), .err_bytes(errb));
    dram_word_model mem (.clk(clk), .rd(req.rd), .flip(flip),
        .mem_wdata(wd), .mem_byte_wr(bwr), .rdata_valid(rvalid),
        .mem_rdata(rdat));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic wr(input logic [1:0] be, input logic [15:0] d);
        req.wr = 1'b1;
        req.byte_en = be;
        req.wdata = d;
        step();
        req.wr = 1'b0;
        chk(bwr, be);
        chk(wd.par, {^d[15:8], ^d[7:0]});
        chk(wd.data, d);
        if (be[1]) shadow[15:8] = d[15:8];
        if (be[0]) shadow[7:0] = d[7:0];
        step();
        chk(bwr, 2'h0);
    endtask : wr
    task automatic rdchk(input logic [17:0] f, input logic [1:0] e);
        req.rd = 1'b1;
        flip = f;
        step();
        req.rd = 1'b0;
        step();
        chk(cpu_rdata, shadow ^ f[15:0]);
        chk(irq, |e);
        chk(errb, e);
    endtask : rdchk
    task automatic acknowledge();
        ack = 1'b1;
        step();
        ack = 1'b0;
        chk({voe, vec, irq, errb}, {1'b1, IRQ_VECTOR_DEF, 3'h0});
        step();
        chk(voe, 1'b0);
    endtask : acknowledge
    task automatic t_byte_writes();
        wr(2'h3, 16'h0000);
        wr(2'h3, 16'h12f7);
        wr(2'h1, 16'h5501);
        wr(2'h2, 16'hc300);
        rdchk(18'h0, 2'h0);
    endtask : t_byte_writes
    task automatic t_single_flips();
        logic [17:0] f[4] = '{18'h00010, 18'h10000, 18'h20000, 18'h08000};
        logic [1:0] e[4] = '{2'h1, 2'h1, 2'h2, 2'h2};
        for (int i = 0; i < 4; i++) begin
            rdchk(f[i], e[i]);
            acknowledge();
        end
        rdchk(18'h00300, 2'h0);
        rdchk(18'h10001, 2'h0);
    endtask : t_single_flips
    task automatic t_ack_meets_error();
        rdchk(18'h00001, 2'h1);
        req.rd = 1'b1;
        flip = 18'h08000;
        step();
        req.rd = 1'b0;
        ack = 1'b1;
        step();
        ack = 1'b0;
        chk({voe, irq, errb}, 4'he);
        acknowledge();
    endtask : t_ack_meets_error
    task automatic t_reset_clears();
        rdchk(18'h00001, 2'h1);
        sys_rst = 1'b1;
        step();
        step();
        sys_rst = 1'b0;
        chk({irq, errb, voe, bwr}, 6'h00);
        rdchk(18'h00000, 2'h0);
    endtask : t_reset_clears
    task automatic t_hold_until_ack();
        rdchk(18'h00001, 2'h1);
        rdchk(18'h00100, 2'h1);
        acknowledge();
        rdchk(18'h00000, 2'h0);
    endtask : t_hold_until_ack
    task automatic tally_and_finish();
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #100us;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        sys_rst = 1'b1;
        ack = 1'b0;
        req = '0;
        flip = '0;
        shadow = '0;
        repeat (5) step();
        sys_rst = 1'b0;
        t_byte_writes();
        t_single_flips();
        t_hold_until_ack();
        t_ack_meets_error();
        t_reset_clears();
        tally_and_finish();
    end
endmodule : byte_parity_error_detector_tb_top
